// [dv/otsc_checker.sv]
// Checker for the OOK threshold and sync pattern register bank.
// Assumes it is bound to otsc_top and sees only that module's ports.
`timescale 1ns/1ns
module otsc_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] threshold_step_size,
  input wire logic [2:0] threshold_decrement_period,
  input wire logic [1:0] average_threshold_cutoff,
  input wire logic [31:0] sync_pattern_value
);
  localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'({otsc_pkg::IDX_OOK_CONFIG, 2'b00});
  localparam logic [ADDR_W-1:0] A_HI = ADDR_W'({otsc_pkg::IDX_SYNC_HI, 2'b00});
  localparam logic [ADDR_W-1:0] A_SEC = ADDR_W'({otsc_pkg::IDX_SYNC_SECOND, 2'b00});
  localparam logic [ADDR_W-1:0] A_THI = ADDR_W'({otsc_pkg::IDX_SYNC_THIRD, 2'b00});
  localparam logic [ADDR_W-1:0] A_FOU = ADDR_W'({otsc_pkg::IDX_SYNC_FOURTH, 2'b00});
  logic [ADDR_W-1:0] aw_reg, aw_next, ar_reg, ar_next;
  logic [7:0] wd_reg, wd_next, cfg;
  logic ws_reg, ws_next, wok;
  assign cfg = {threshold_step_size, threshold_decrement_period, average_threshold_cutoff};
  // Last write address, low data byte and lane 0 strobe, last read address
  always_comb begin
    aw_next = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_reg;
    ar_next = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_reg;
    wd_next = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : wd_reg;
    ws_next = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : ws_reg;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_reg <= '0;
      ar_reg <= '0;
      wd_reg <= 8'h00;
      ws_reg <= 1'b0;
    end else begin
      aw_reg <= aw_next;
      ar_reg <= ar_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
    end
  end
  assign wok = s_axi_bvalid && s_axi_bresp == otsc_pkg::RESP_OKAY && ws_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  write_latency_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  read_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cfg_write_a: assert property (
    $rose(s_axi_bvalid) && wok && aw_reg == A_CFG |-> cfg == wd_reg)
    else $error("config fields not written");
  cfg_hold_a: assert property (
    !$rose(s_axi_bvalid) |-> $stable(cfg))
    else $error("config fields changed alone");
  sync_hi_a: assert property (
    $rose(s_axi_bvalid) && wok && aw_reg == A_HI
    |-> sync_pattern_value[31:24] == wd_reg) else $error("first sync byte wrong");
  sync_second_a: assert property (
    $rose(s_axi_bvalid) && wok && aw_reg == A_SEC
    |-> sync_pattern_value[23:16] == wd_reg) else $error("second sync byte wrong");
  sync_third_a: assert property (
    $rose(s_axi_bvalid) && wok && aw_reg == A_THI
    |-> sync_pattern_value[15:8] == wd_reg) else $error("third sync byte wrong");
  sync_fourth_a: assert property (
    $rose(s_axi_bvalid) && wok && aw_reg == A_FOU
    |-> sync_pattern_value[7:0] == wd_reg) else $error("fourth sync byte wrong");
  cfg_read_a: assert property (
    $rose(s_axi_rvalid) && ar_reg == A_CFG
    |-> s_axi_rdata == {24'h000000, cfg}) else $error("config readback wrong");
  cover property ($rose(s_axi_bvalid) && wok && aw_reg == A_CFG);
  cover property ($rose(s_axi_rvalid) && ar_reg == A_THI);
  cover property (s_axi_bvalid && s_axi_bresp == otsc_pkg::RESP_SLVERR);
endmodule
bind otsc_top otsc_checker #(.ADDR_W(ADDR_W)) otsc_checker_i (.clk(clk), .rstn(rstn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .threshold_step_size(threshold_step_size),
  .threshold_decrement_period(threshold_decrement_period),
  .average_threshold_cutoff(average_threshold_cutoff), .sync_pattern_value(sync_pattern_value));

// [dv/tb.sv]
// Testbench for the OOK threshold and sync pattern register bank.
// Assumes otsc_top with an AXI4-Lite slave; the checker is bound separately.
`timescale 1ns/1ns
module tb;
  logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, obit;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, sync;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, cut, c;
  logic [2:0] step, period;
  logic [7:0] rssi, d, peak, p;
  int fails, total_checks, cycles;
  otsc_top #(.ADDR_W(12), .SUBTICK_CYCLES(1)) otsc_top_i (.clk(clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .signal_strength_value(rssi), .threshold_step_size(step),
    .threshold_decrement_period(period), .average_threshold_cutoff(cut),
    .sync_pattern_value(sync), .ook_peak_threshold(peak), .ook_avg_threshold(),
    .ook_bit(obit));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic axi_write(input logic [9:0] idx, input logic [31:0] dat, input logic [3:0] st,
      input logic [1:0] er);
    logic a, w, ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= dat;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      a = awvalid && awready;
      w = wvalid && wready;
      @(posedge clk);
      if (a) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (w) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    bready <= 1'b1;
    @(negedge clk);
    check({30'h0, bresp}, {30'h0, er}, "write response");
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    rready <= 1'b1;
    @(negedge clk);
    check(rdata, exp, "read data");
    check({30'h0, rresp}, {30'h0, er}, "read response");
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic check_defaults();
    check({24'h0, step, period, cut}, 32'h0, "config port after reset");
    check(sync, 32'h0, "sync port after reset");
    axi_read(otsc_pkg::IDX_OOK_CONFIG, 32'h0, otsc_pkg::RESP_OKAY);
    axi_read(otsc_pkg::IDX_SYNC_HI, 32'h0, otsc_pkg::RESP_OKAY);
    axi_read(otsc_pkg::IDX_SYNC_SECOND, 32'h0, otsc_pkg::RESP_OKAY);
    axi_read(otsc_pkg::IDX_SYNC_THIRD, 32'h0, otsc_pkg::RESP_OKAY);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb, rssi} = '0;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    do_reset();
    check_defaults();
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      c = i[0] ? otsc_pkg::CUTOFF_BR32 : otsc_pkg::CUTOFF_BR8;
      d = {i[2:0], 3'(7 - i), c};
      axi_write(otsc_pkg::IDX_OOK_CONFIG, {24'hA5A5A5, d}, 4'hF, otsc_pkg::RESP_OKAY);
      check(32'(step), 32'(d[7:5]), "step field");
      check(32'(period), 32'(d[4:2]), "period field");
      check(32'(cut), 32'(d[1:0]), "cutoff field");
      axi_read(otsc_pkg::IDX_OOK_CONFIG, {24'h0, d}, otsc_pkg::RESP_OKAY);
    end
    $display("config fields done");
    axi_write(otsc_pkg::IDX_SYNC_HI, 32'h5A, 4'h1, otsc_pkg::RESP_OKAY);
    axi_write(otsc_pkg::IDX_SYNC_SECOND, 32'h3C, 4'h1, otsc_pkg::RESP_OKAY);
    axi_write(otsc_pkg::IDX_SYNC_THIRD, 32'h96, 4'h1, otsc_pkg::RESP_OKAY);
    axi_write(otsc_pkg::IDX_SYNC_FOURTH, 32'hC3, 4'h1, otsc_pkg::RESP_OKAY);
    axi_write(10'h038, 32'hFF, 4'h1, otsc_pkg::RESP_SLVERR);
    axi_write(otsc_pkg::IDX_SYNC_HI, 32'hFF, 4'hE, otsc_pkg::RESP_OKAY);
    check(sync, 32'h5A3C96C3, "sync pattern");
    axi_read(otsc_pkg::IDX_SYNC_HI, 32'h5A, otsc_pkg::RESP_OKAY);
    axi_read(otsc_pkg::IDX_SYNC_SECOND, 32'h3C, otsc_pkg::RESP_OKAY);
    axi_read(otsc_pkg::IDX_SYNC_THIRD, 32'h96, otsc_pkg::RESP_OKAY);
    axi_read(10'h3FF, 32'h0, otsc_pkg::RESP_SLVERR);
    $display("sync bytes done");
    rssi <= 8'h6B;
    repeat (4) @(posedge clk);
    axi_read(otsc_pkg::IDX_SIGNAL_STRENGTH, 32'h6B, otsc_pkg::RESP_OKAY);
    axi_write(otsc_pkg::IDX_SIGNAL_STRENGTH, 32'h11, 4'h1, otsc_pkg::RESP_SLVERR);
    axi_read(otsc_pkg::IDX_SIGNAL_STRENGTH, 32'h6B, otsc_pkg::RESP_OKAY);
    $display("signal strength done");
    axi_write(otsc_pkg::IDX_OOK_CONFIG, 32'hFC, 4'h1, otsc_pkg::RESP_OKAY);
    rssi <= 8'h00;
    repeat (4) @(posedge clk);
    @(negedge clk);
    p = peak;
    @(negedge clk);
    check({24'h0, p - peak}, 32'h0C, "peak step per sub tick");
    repeat (12) @(negedge clk);
    check({24'h0, peak}, 32'h0, "peak floor");
    check({31'h0, obit}, 32'h1, "ook bit at floor");
    @(posedge clk);
    $display("threshold decay done");
    do_reset();
    check_defaults();
    $display("second reset done");
    finish_test();
  end
endmodule

// [rtl/otsc_pkg.sv]
// Constants for the OOK threshold and sync pattern configuration block.
// Assumes a 32-bit AXI4-Lite slave; register index times four is the byte address.
// Operation
// - The 3-bit step code selects 0.5, 1.0, 1.5, 2.0, 3.0, 4.0, 5.0 or 6.0 dB per decrement.
// - The 3-bit period code selects 1, 1/2, 1/4, 1/8 or 2, 4, 8, 16 decrements per chip.
// - The 2-bit cut-off code 00 averages near BR/8pi and 11 near BR/32pi.
// - The OOK config register holds step in bits 7:5, period in 4:2, cut-off in 1:0.
// - The OOK config register is zero after reset.
// - The first sync byte register holds pattern bits 31:24, read/write, reset zero.
// - The second sync byte register holds pattern bits 23:16, read/write, reset zero.
// - The third sync byte register holds pattern bits 15:8, read/write, reset zero.
// - The signal strength value is an 8-bit read-only measure in 0.5 dB units.
// - A fourth sync byte register holds pattern bits 7:0, completing the 32 bits.
package otsc_pkg;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_SIGNAL_STRENGTH = 10'h014;
  localparam logic [IDX_W-1:0] IDX_OOK_CONFIG = 10'h015;
  localparam logic [IDX_W-1:0] IDX_SYNC_HI = 10'h016;
  localparam logic [IDX_W-1:0] IDX_SYNC_SECOND = 10'h017;
  localparam logic [IDX_W-1:0] IDX_SYNC_THIRD = 10'h138;
  localparam logic [IDX_W-1:0] IDX_SYNC_FOURTH = 10'h019;
  localparam logic [IDX_W-1:0] IDX_THRESH_STATUS = 10'h020;
  localparam logic [7:0] OOK_CONFIG_RST = 8'h00;
  localparam logic [7:0] SYNC_BYTE_RST = 8'h00;
  localparam int STEP_MSB = 7;
  localparam int STEP_LSB = 5;
  localparam int PERIOD_MSB = 4;
  localparam int PERIOD_LSB = 2;
  localparam int CUTOFF_MSB = 1;
  localparam int CUTOFF_LSB = 0;
  localparam logic [1:0] CUTOFF_BR8 = 2'h0;
  localparam logic [1:0] CUTOFF_BR32 = 2'h3;
  localparam int AVG_SHIFT_BR8 = 3;
  localparam int AVG_SHIFT_BR32 = 5;
  localparam int SUBTICKS_PER_CHIP = 16;
  localparam int DEF_SUBTICK_CYCLES = 4;
  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Step size in 0.5 dB units
  function automatic logic [7:0] step_half_db(input logic [2:0] code);
    logic [7:0] s;
    unique case (code)
      3'h0: s = 8'h01;
      3'h1: s = 8'h02;
      3'h2: s = 8'h03;
      3'h3: s = 8'h04;
      3'h4: s = 8'h06;
      3'h5: s = 8'h08;
      3'h6: s = 8'h0A;
      default: s = 8'h0C;
    endcase
    return s;
  endfunction
endpackage

// [rtl/otsc_thresh_track.sv]
// OOK threshold tracker: decaying peak threshold and averaged threshold.
// Assumes sub_tick pulses sixteen times per chip and chip_tick once per chip, same clock.
`timescale 1ns/1ns
module otsc_thresh_track (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sub_tick,
  input wire logic chip_tick,
  input wire logic [7:0] rssi,
  input wire logic [2:0] step_code,
  input wire logic [2:0] period_code,
  input wire logic [1:0] cutoff_code,
  output logic [7:0] peak_thr,
  output logic [7:0] avg_thr,
  output logic ook_bit
);
  logic [6:0] sub_cnt_reg, sub_cnt_next;
  logic [7:0] peak_reg, peak_next;
  logic [15:0] acc_reg, acc_next;
  logic bit_reg, bit_next;
  logic [6:0] mask;
  logic dec_now;
  logic [7:0] step;
  logic signed [16:0] diff;
  logic signed [16:0] delta;

  // Sub-tick interval mask per period code
  always_comb begin
    unique case (period_code)
      3'h0: mask = 7'h0F;
      3'h1: mask = 7'h1F;
      3'h2: mask = 7'h3F;
      3'h3: mask = 7'h7F;
      3'h4: mask = 7'h07;
      3'h5: mask = 7'h03;
      3'h6: mask = 7'h01;
      default: mask = 7'h00;
    endcase
  end

  always_comb begin
    step = otsc_pkg::step_half_db(step_code);
    dec_now = sub_tick && ((sub_cnt_reg & mask) == mask);
    sub_cnt_next = sub_tick ? sub_cnt_reg + 7'h01 : sub_cnt_reg;
    peak_next = peak_reg;
    if (sub_tick) begin
      if (rssi > peak_reg) begin
        peak_next = rssi;
      end else if (dec_now) begin
        peak_next = (peak_reg > step) ? peak_reg - step : 8'h00;
      end
    end
    bit_next = sub_tick ? (rssi >= peak_reg) : bit_reg;
  end

  // Averaging filter; reserved cut-off codes fall back to the fast corner of code 00
  always_comb begin
    diff = $signed({1'b0, rssi, 8'h00}) - $signed({1'b0, acc_reg});
    if (cutoff_code == otsc_pkg::CUTOFF_BR32) begin
      delta = diff >>> otsc_pkg::AVG_SHIFT_BR32;
    end else begin
      delta = diff >>> otsc_pkg::AVG_SHIFT_BR8;
    end
    acc_next = chip_tick ? 16'(acc_reg + delta[15:0]) : acc_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_cnt_reg <= 7'h00;
      peak_reg <= otsc_pkg::THRESH_RST;
      acc_reg <= 16'h0000;
      bit_reg <= 1'b0;
    end else begin
      sub_cnt_reg <= sub_cnt_next;
      peak_reg <= peak_next;
      acc_reg <= acc_next;
      bit_reg <= bit_next;
    end
  end

  assign peak_thr = peak_reg;
  assign avg_thr = acc_reg[15:8];
  assign ook_bit = bit_reg;
endmodule

// [rtl/otsc_top.sv]
// Register bank for OOK threshold and sync pattern, AXI4-Lite slave.
// Assumes the signal strength input is asynchronous; one clock, reset released in sync.
`timescale 1ns/1ns
module otsc_top #(
  parameter int ADDR_W = 12,
  parameter int SUBTICK_CYCLES = otsc_pkg::DEF_SUBTICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] signal_strength_value,
  output logic [2:0] threshold_step_size,
  output logic [2:0] threshold_decrement_period,
  output logic [1:0] average_threshold_cutoff,
  output logic [31:0] sync_pattern_value,
  output logic [7:0] ook_peak_threshold,
  output logic [7:0] ook_avg_threshold,
  output logic ook_bit
);
  // Reset release
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // Signal strength pin synchroniser
  logic [7:0] rssi_meta_reg;
  logic [7:0] rssi_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rssi_meta_reg <= 8'h00;
      rssi_reg <= 8'h00;
    end else begin
      rssi_meta_reg <= signal_strength_value;
      rssi_reg <= rssi_meta_reg;
    end
  end

  // Sub-chip and chip rate enables
  localparam int SUB_W = $clog2(SUBTICK_CYCLES + 1);
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(SUBTICK_CYCLES - 1);
  localparam logic [3:0] CHIP_LAST = 4'(otsc_pkg::SUBTICKS_PER_CHIP - 1);
  logic [SUB_W-1:0] div_reg, div_next;
  logic [3:0] chip_reg, chip_next;
  logic sub_tick_reg, sub_tick_next;
  logic chip_tick_reg, chip_tick_next;

  always_comb begin
    div_next = div_reg;
    chip_next = chip_reg;
    sub_tick_next = 1'b0;
    chip_tick_next = 1'b0;
    if (div_reg == SUB_LAST) begin
      div_next = '0;
      sub_tick_next = 1'b1;
      if (chip_reg == CHIP_LAST) begin
        chip_next = 4'h0;
        chip_tick_next = 1'b1;
      end else begin
        chip_next = chip_reg + 4'h1;
      end
    end else begin
      div_next = div_reg + SUB_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
      chip_reg <= 4'h0;
      sub_tick_reg <= 1'b0;
      chip_tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      chip_reg <= chip_next;
      sub_tick_reg <= sub_tick_next;
      chip_tick_reg <= chip_tick_next;
    end
  end

  // Configuration registers
  logic [7:0] ook_threshold_config_reg, ook_threshold_config_next;
  logic [7:0] sync_pattern_byte_hi_reg, sync_pattern_byte_hi_next;
  logic [7:0] sync_pattern_byte_second_reg, sync_pattern_byte_second_next;
  logic [7:0] sync_pattern_byte_third_reg, sync_pattern_byte_third_next;
  logic [7:0] sync_pattern_byte_fourth_reg, sync_pattern_byte_fourth_next;

  // Write channel state
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [otsc_pkg::IDX_W-1:0] aw_idx_reg, aw_idx_next;
  logic [7:0] w_byte_reg, w_byte_next;
  logic w_lane_reg, w_lane_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic commit;
  logic wr_hit;

  always_comb begin
    unique case (aw_idx_reg)
      otsc_pkg::IDX_OOK_CONFIG,
      otsc_pkg::IDX_SYNC_HI,
      otsc_pkg::IDX_SYNC_SECOND,
      otsc_pkg::IDX_SYNC_THIRD,
      otsc_pkg::IDX_SYNC_FOURTH: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    aw_idx_next = aw_idx_reg;
    w_byte_next = w_byte_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ook_threshold_config_next = ook_threshold_config_reg;
    sync_pattern_byte_hi_next = sync_pattern_byte_hi_reg;
    sync_pattern_byte_second_next = sync_pattern_byte_second_reg;
    sync_pattern_byte_third_next = sync_pattern_byte_third_reg;
    sync_pattern_byte_fourth_next = sync_pattern_byte_fourth_reg;
    commit = aw_got_reg && w_got_reg && !bvalid_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      aw_idx_next = s_axi_awaddr[otsc_pkg::IDX_W+1:2];
    end
    if (s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      w_byte_next = s_axi_wdata[7:0];
      w_lane_next = s_axi_wstrb[0];
    end
    if (commit) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? otsc_pkg::RESP_OKAY : otsc_pkg::RESP_SLVERR;
      if (w_lane_reg) begin
        unique case (aw_idx_reg)
          otsc_pkg::IDX_OOK_CONFIG: ook_threshold_config_next = w_byte_reg;
          otsc_pkg::IDX_SYNC_HI: sync_pattern_byte_hi_next = w_byte_reg;
          otsc_pkg::IDX_SYNC_SECOND: sync_pattern_byte_second_next = w_byte_reg;
          otsc_pkg::IDX_SYNC_THIRD: sync_pattern_byte_third_next = w_byte_reg;
          otsc_pkg::IDX_SYNC_FOURTH: sync_pattern_byte_fourth_next = w_byte_reg;
          default: begin
          end
        endcase
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next = !w_got_next && !bvalid_next;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= '0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= otsc_pkg::RESP_OKAY;
      ook_threshold_config_reg <= otsc_pkg::OOK_CONFIG_RST;
      sync_pattern_byte_hi_reg <= otsc_pkg::SYNC_BYTE_RST;
      sync_pattern_byte_second_reg <= otsc_pkg::SYNC_BYTE_RST;
      sync_pattern_byte_third_reg <= otsc_pkg::SYNC_BYTE_RST;
      sync_pattern_byte_fourth_reg <= otsc_pkg::SYNC_BYTE_RST;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      aw_idx_reg <= aw_idx_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      ook_threshold_config_reg <= ook_threshold_config_next;
      sync_pattern_byte_hi_reg <= sync_pattern_byte_hi_next;
      sync_pattern_byte_second_reg <= sync_pattern_byte_second_next;
      sync_pattern_byte_third_reg <= sync_pattern_byte_third_next;
      sync_pattern_byte_fourth_reg <= sync_pattern_byte_fourth_next;
    end
  end

  // Threshold tracker
  logic [7:0] peak_thr;
  logic [7:0] avg_thr;
  logic thr_bit;

  otsc_thresh_track u_track (
    .clk(clk),
    .rst_n(rst_n),
    .sub_tick(sub_tick_reg),
    .chip_tick(chip_tick_reg),
    .rssi(rssi_reg),
    .step_code(ook_threshold_config_reg[otsc_pkg::STEP_MSB:otsc_pkg::STEP_LSB]),
    .period_code(ook_threshold_config_reg[otsc_pkg::PERIOD_MSB:otsc_pkg::PERIOD_LSB]),
    .cutoff_code(ook_threshold_config_reg[otsc_pkg::CUTOFF_MSB:otsc_pkg::CUTOFF_LSB]),
    .peak_thr(peak_thr),
    .avg_thr(avg_thr),
    .ook_bit(thr_bit)
  );

  // Read channel
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [otsc_pkg::IDX_W-1:0] ar_idx;
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    ar_idx = s_axi_araddr[otsc_pkg::IDX_W+1:2];
    rd_hit = 1'b1;
    unique case (ar_idx)
      otsc_pkg::IDX_SIGNAL_STRENGTH: rd_word = {24'h000000, rssi_reg};
      otsc_pkg::IDX_OOK_CONFIG: rd_word = {24'h000000, ook_threshold_config_reg};
      otsc_pkg::IDX_SYNC_HI: rd_word = {24'h000000, sync_pattern_byte_hi_reg};
      otsc_pkg::IDX_SYNC_SECOND: rd_word = {24'h000000, sync_pattern_byte_second_reg};
      otsc_pkg::IDX_SYNC_THIRD: rd_word = {24'h000000, sync_pattern_byte_third_reg};
      otsc_pkg::IDX_SYNC_FOURTH: rd_word = {24'h000000, sync_pattern_byte_fourth_reg};
      otsc_pkg::IDX_THRESH_STATUS: rd_word = {15'h0000, thr_bit, avg_thr, peak_thr};
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = rd_hit ? otsc_pkg::RESP_OKAY : otsc_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= otsc_pkg::RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign threshold_step_size =
    ook_threshold_config_reg[otsc_pkg::STEP_MSB:otsc_pkg::STEP_LSB];
  assign threshold_decrement_period =
    ook_threshold_config_reg[otsc_pkg::PERIOD_MSB:otsc_pkg::PERIOD_LSB];
  assign average_threshold_cutoff =
    ook_threshold_config_reg[otsc_pkg::CUTOFF_MSB:otsc_pkg::CUTOFF_LSB];
  assign sync_pattern_value = {sync_pattern_byte_hi_reg, sync_pattern_byte_second_reg,
    sync_pattern_byte_third_reg, sync_pattern_byte_fourth_reg};
  assign ook_peak_threshold = peak_thr;
  assign ook_avg_threshold = avg_thr;
  assign ook_bit = thr_bit;
endmodule
